// ===== psuhk_pkg.sv
// Package with timing constants, state encodings and register map of the sequencer.
package psuhk_pkg;

  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;

  // Times in milliseconds as specified.
  localparam int unsigned GOOD_DLY_MIN_MS = 100;
  localparam int unsigned GOOD_DLY_MAX_MS = 500;
  localparam int unsigned GOOD_DLY_MS     = 200;
  localparam int unsigned WARN_MS         = 1;
  localparam int unsigned WARN_HOLD_MS    = 2;
  localparam int unsigned ON_TIME_MAX_MS  = 500;
  localparam int unsigned SB_TIME_MAX_MS  = 2000;
  localparam int unsigned RESTART_OFF_MS  = 1000;
  localparam int unsigned DEBOUNCE_MS     = 20;

  // Cycle counts derived from the clock rate.
  localparam int unsigned GOOD_DLY_CYC    = GOOD_DLY_MS * CYC_PER_MS;
  localparam int unsigned WARN_HOLD_CYC   = WARN_HOLD_MS * CYC_PER_MS;
  localparam int unsigned ON_TIME_CYC     = ON_TIME_MAX_MS * CYC_PER_MS;
  localparam int unsigned SB_TIME_CYC     = SB_TIME_MAX_MS * CYC_PER_MS;
  localparam int unsigned RESTART_CYC     = RESTART_OFF_MS * CYC_PER_MS;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned TACH_TMO_CYC    = 250 * CYC_PER_MS;

  localparam int unsigned CNT_W           = 26;

  // Register byte offsets.
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_STATUS     = 12'h004;
  localparam logic [11:0] ADDR_FAN        = 12'h008;

  // Control register fields.
  localparam int unsigned CTRL_FAN_SEL    = 0;
  localparam int unsigned CTRL_FAULT_CLR  = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;

  // Fan drive levels.
  localparam logic [1:0]  FAN_OFF         = 2'h0;
  localparam logic [1:0]  FAN_MIN         = 2'h1;
  localparam logic [1:0]  FAN_THERMAL     = 2'h2;
  localparam logic [1:0]  FAN_MAX         = 2'h3;

  typedef enum logic [5:0] {
    ST_STANDBY = 6'b000001,
    ST_RAMP    = 6'b000010,
    ST_DELAY   = 6'b000100,
    ST_RUN     = 6'b001000,
    ST_WARN    = 6'b010000,
    ST_FAULT   = 6'b100000
  } psuhk_state_e;

endpackage

// ===== psuhk_deb_if.sv
// Interface between the sequencer and its input filter.
`timescale 1ns/1ps
interface psuhk_deb_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ===== psuhk_debounce.sv
// Two-flop synchroniser followed by a stable-time filter.
`timescale 1ns/1ps
module psuhk_debounce #(
  parameter int unsigned STABLE_CYC = psuhk_pkg::DEBOUNCE_CYC,
  parameter logic        INIT       = 1'b1
) (
  // Clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // Filtered signal
  psuhk_deb_if.filt  d
);

  typedef struct packed {
    logic                          s1;
    logic                          s2;
    logic                          clean;
    logic [psuhk_pkg::CNT_W-1:0]   cnt;
  } psuhk_deb_s;

  psuhk_deb_s st_r;
  psuhk_deb_s st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d.raw;
    st_nxt.s2 = st_r.s1;
    // The output only follows after the input stayed put long enough.
    if (st_r.s2 == st_r.clean) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= psuhk_pkg::CNT_W'(STABLE_CYC - 1)) begin
      st_nxt.clean = st_r.s2;
      st_nxt.cnt   = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{s1: INIT, s2: INIT, clean: INIT, cnt: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign d.clean = st_r.clean;

endmodule // psuhk_debounce

// ===== psuhk_seq.sv
// Housekeeping sequencer of the supply: rails, power good, faults and fans.
// Overview of operation
// - Power good high only with all main rails good and energy stored.
// - Power good low on any rail under voltage or input energy lost; only main_rails_ok is checked, not standby_rails_ok.
// - Power good rises 100 to 500 ms after rails reach regulation.
// - Power good falls at least 1 ms before rails are dropped; on output_fault both fall together, on main_rails_ok loss 2 cycles apart.
// - Sleep low disables main rails except aux, standby and digital 12 V.
// - Sleep high or open keeps outputs enabled; pin reads high open.
// - Sleep turns one fan off, the other to minimum speed, or to maximum on override.
// - Remote-on and sleep pair decoded into off, sleep, run, invalid.
// - Main outputs on when remote-on request low, off when high.
// - Auxiliary and standby rails on whenever AC is present.
// - Remote-on input is debounced against mechanical switch bounce.
// - Main rails must reach regulation within 500 ms of request.
// - Standby rails must regulate within 2 s of AC applied.
// - Latched fault clears only after fault gone and 1 s off cycle.
// - Fan override request forces the running fans to maximum speed; in sleep one fan stays off.
// - Fans are off in the remote-off state.
// - Tachometer output gives 2 pulses per fan revolution.
// - Locked rotor on any fan stops the tachometer output toggling.
// - Tachometer follows one fan but stops on a lock of either.
// - Supply works whether or not the tachometer is used.
`timescale 1ns/1ps
module psuhk_seq #(
  parameter int unsigned GOOD_DLY_CYC = psuhk_pkg::GOOD_DLY_CYC,
  parameter int unsigned WARN_CYC     = psuhk_pkg::WARN_HOLD_CYC,
  parameter int unsigned ON_TMO_CYC   = psuhk_pkg::ON_TIME_CYC,
  parameter int unsigned SB_TMO_CYC   = psuhk_pkg::SB_TIME_CYC,
  parameter int unsigned RESTART_CYC  = psuhk_pkg::RESTART_CYC,
  parameter int unsigned DEBOUNCE_CYC = psuhk_pkg::DEBOUNCE_CYC,
  parameter int unsigned TACH_TMO_CYC = psuhk_pkg::TACH_TMO_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System board pins
  input  wire logic        remote_on_request_n,
  input  wire logic        sleep_request_n,
  input  wire logic        fan_max_speed_request_n,
  output logic             power_good_out,
  output logic             fan_tach_out,
  output logic             fan_tach_oe,
  // Supply monitors
  input  wire logic        ac_ok,
  input  wire logic        energy_ok,
  input  wire logic        main_rails_ok,
  input  wire logic        standby_rails_ok,
  input  wire logic        output_fault,
  input  wire logic        fan_a_tach,
  input  wire logic        fan_b_tach,
  // Rail enables and fan drive
  output logic             main_rails_en,
  output logic             digital_12v_rail_en,
  output logic             standby_5v_rail_en,
  output logic             fan_a_drive_on,
  output logic [1:0]       fan_a_level,
  output logic             fan_b_drive_on,
  output logic [1:0]       fan_b_level
);

  localparam int W = psuhk_pkg::CNT_W;

  typedef struct packed {
    psuhk_pkg::psuhk_state_e st;
    logic [W-1:0]            tmr;
    logic [W-1:0]            off_tmr;
    logic                    off_done;
    logic [W-1:0]            sb_tmr;
    logic                    sb_late;
    logic                    on_late;
    logic                    fault_seen;
    logic [5:0]              sync;
    logic [3:0]              tach_d;
    logic [W-1:0]            lock_a_tmr;
    logic [W-1:0]            lock_b_tmr;
    logic                    tach_q;
    logic [1:0]              ctrl;
    logic [31:0]             rdata;
  } psuhk_seq_s;

  psuhk_seq_s   s_r;
  psuhk_seq_s   s_nxt;
  psuhk_deb_if  deb ();

  // Fan state is derived per fan, hence a small shared helper.
  function automatic logic lock_seen(input logic [W-1:0] t);
    return t >= W'(TACH_TMO_CYC);
  endfunction

  function automatic logic [W-1:0] bump(input logic [W-1:0] t);
    return (t == '1) ? t : t + 1'b1;
  endfunction

  psuhk_debounce #(
    .STABLE_CYC (DEBOUNCE_CYC),
    .INIT       (1'b1)
  ) u_on_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (deb.filt)
  );

  assign deb.raw = remote_on_request_n;

  // Synchronised pins: [1:0] sleep, [3:2] override, [5:4] first tach flops.
  // The tach second stages and their edge history live in tach_d.
  logic sleep_n_s;
  logic fanmax_n_s;
  logic on_req;
  logic sleep_req;
  logic invalid_pair;
  logic want_main;
  logic lock_any;
  logic wr_en;
  logic rd_en;

  assign sleep_n_s    = s_r.sync[1];
  assign fanmax_n_s   = s_r.sync[3];
  assign on_req       = ~deb.clean;
  assign sleep_req    = ~sleep_n_s;
  assign invalid_pair = ~on_req & sleep_req;
  assign want_main    = on_req & ~sleep_req & ac_ok;
  assign lock_any     = lock_seen(s_r.lock_a_tmr) |
                        lock_seen(s_r.lock_b_tmr);
  assign wr_en        = psel & penable & pwrite;
  assign rd_en        = psel & ~penable & ~pwrite;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.sync = {fan_b_tach, s_r.sync[4], fan_max_speed_request_n,
                  s_r.sync[2], sleep_request_n, s_r.sync[0]};
    s_nxt.sync[4] = fan_a_tach;
    s_nxt.sync[0] = sleep_request_n;
    s_nxt.sync[1] = s_r.sync[0];
    s_nxt.sync[2] = fan_max_speed_request_n;
    s_nxt.sync[3] = s_r.sync[2];
    s_nxt.sync[5] = fan_b_tach;
    s_nxt.tach_d  = {s_r.tach_d[1:0], s_r.sync[5], s_r.sync[4]};

    // Off time for restart: request released or AC absent.
    if (!on_req || !ac_ok) begin
      s_nxt.off_tmr = bump(s_r.off_tmr);
      if (s_r.off_tmr >= W'(RESTART_CYC - 1)) begin
        s_nxt.off_done = 1'b1;
      end
    end else begin
      s_nxt.off_tmr = '0;
    end

    // Standby rail watchdog.
    if (!ac_ok) begin
      s_nxt.sb_tmr = '0;
    end else if (!standby_rails_ok) begin
      s_nxt.sb_tmr = bump(s_r.sb_tmr);
      if (s_r.sb_tmr >= W'(SB_TMO_CYC)) begin
        s_nxt.sb_late = 1'b1;
      end
    end

    s_nxt.tmr = bump(s_r.tmr);
    case (s_r.st)
      psuhk_pkg::ST_STANDBY: begin
        s_nxt.tmr = '0;
        if (want_main && !output_fault) begin
          s_nxt.st      = psuhk_pkg::ST_RAMP;
          s_nxt.on_late = 1'b0;
        end
      end
      psuhk_pkg::ST_RAMP: begin
        if (!want_main) begin
          s_nxt.st = psuhk_pkg::ST_STANDBY;
        end else if (main_rails_ok) begin
          s_nxt.st  = psuhk_pkg::ST_DELAY;
          s_nxt.tmr = '0;
        end else if (s_r.tmr >= W'(ON_TMO_CYC)) begin
          s_nxt.st      = psuhk_pkg::ST_FAULT;
          s_nxt.on_late = 1'b1;
        end
      end
      psuhk_pkg::ST_DELAY: begin
        if (!want_main) begin
          s_nxt.st = psuhk_pkg::ST_STANDBY;
        end else if (!main_rails_ok) begin
          s_nxt.st  = psuhk_pkg::ST_RAMP;
          s_nxt.tmr = '0;
        end else if (s_r.tmr >= W'(GOOD_DLY_CYC - 1) && energy_ok) begin
          s_nxt.st = psuhk_pkg::ST_RUN;
        end
      end
      psuhk_pkg::ST_RUN: begin
        // Good falls first; rails stay on through the warning time unless main_rails_ok is lost, which ends it after one cycle.
        if (!want_main || !energy_ok || !main_rails_ok) begin
          s_nxt.st  = psuhk_pkg::ST_WARN;
          s_nxt.tmr = '0;
        end
      end
      psuhk_pkg::ST_WARN: begin
        if (s_r.tmr >= W'(WARN_CYC - 1) || !main_rails_ok) begin
          s_nxt.st = psuhk_pkg::ST_STANDBY;
        end
      end
      psuhk_pkg::ST_FAULT: begin
        if (!output_fault && s_r.off_done && on_req && ac_ok) begin
          s_nxt.st = psuhk_pkg::ST_STANDBY;
        end
      end
      default: s_nxt.st = psuhk_pkg::ST_STANDBY;
    endcase

    // A fault during any powered state latches the supply off.
    if (output_fault && s_r.st != psuhk_pkg::ST_STANDBY) begin
      s_nxt.st = psuhk_pkg::ST_FAULT;
    end
    if (s_nxt.st == psuhk_pkg::ST_FAULT && s_r.st != psuhk_pkg::ST_FAULT) begin
      s_nxt.off_done   = 1'b0;
      s_nxt.off_tmr    = '0;
      s_nxt.fault_seen = 1'b1;
    end

    // Locked-rotor detection: no edge for too long on a running fan.
    if (!fan_a_drive_on || s_r.tach_d[0] != s_r.tach_d[2]) begin
      s_nxt.lock_a_tmr = '0;
    end else begin
      s_nxt.lock_a_tmr = bump(s_r.lock_a_tmr);
    end
    if (!fan_b_drive_on || s_r.tach_d[1] != s_r.tach_d[3]) begin
      s_nxt.lock_b_tmr = '0;
    end else begin
      s_nxt.lock_b_tmr = bump(s_r.lock_b_tmr);
    end
    // Fan A already gives 2 pulses per turn; freeze on any lock.
    if (!lock_any) begin
      s_nxt.tach_q = s_r.tach_d[0];
    end

    // APB register access.
    if (wr_en && paddr == psuhk_pkg::ADDR_CTRL) begin
      s_nxt.ctrl = pwdata[1:0];
    end
    if (wr_en && paddr == psuhk_pkg::ADDR_CTRL &&
        pwdata[psuhk_pkg::CTRL_FAULT_CLR] &&
        !(s_nxt.st == psuhk_pkg::ST_FAULT && s_r.st != psuhk_pkg::ST_FAULT)) begin
      s_nxt.fault_seen = 1'b0;
    end
    if (rd_en) begin
      if (paddr == psuhk_pkg::ADDR_CTRL) begin
        s_nxt.rdata = {30'h0, s_r.ctrl};
      end else if (paddr == psuhk_pkg::ADDR_STATUS) begin
        s_nxt.rdata = {18'h0, s_r.st, s_r.sb_late, s_r.on_late,
                       s_r.fault_seen, invalid_pair, sleep_req, on_req,
                       power_good_out, main_rails_en};
      end else if (paddr == psuhk_pkg::ADDR_FAN) begin
        s_nxt.rdata = {26'h0, lock_seen(s_r.lock_b_tmr),
                       lock_seen(s_r.lock_a_tmr), fan_b_level, fan_a_level};
      end else begin
        s_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r       <= '0;
      s_r.st    <= psuhk_pkg::ST_STANDBY;
      s_r.sync  <= 6'h0F;
      s_r.ctrl  <= psuhk_pkg::CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  logic unmapped;
  assign unmapped = paddr != psuhk_pkg::ADDR_CTRL &&
                    paddr != psuhk_pkg::ADDR_STATUS &&
                    paddr != psuhk_pkg::ADDR_FAN;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & unmapped;
  assign prdata  = s_r.rdata;

  // Good only in RUN, which needs rails and energy good.
  assign power_good_out = (s_r.st == psuhk_pkg::ST_RUN) & main_rails_ok &
                          energy_ok;
  assign main_rails_en  = (s_r.st == psuhk_pkg::ST_RAMP ||
                           s_r.st == psuhk_pkg::ST_DELAY ||
                           s_r.st == psuhk_pkg::ST_RUN ||
                           s_r.st == psuhk_pkg::ST_WARN);
  assign digital_12v_rail_en = main_rails_en |
                               (on_req & sleep_req & ac_ok &
                                s_r.st != psuhk_pkg::ST_FAULT);
  assign standby_5v_rail_en  = ac_ok;

  // Open-collector output: drive low only, pull-up is off chip.
  assign fan_tach_out = 1'b0;
  assign fan_tach_oe  = ~s_r.tach_q;

  logic sleeping;
  logic fan_sel_b;
  logic [1:0] run_lvl;
  assign sleeping  = on_req & sleep_req & ac_ok;
  assign fan_sel_b = s_r.ctrl[psuhk_pkg::CTRL_FAN_SEL];
  assign run_lvl   = !fanmax_n_s ? psuhk_pkg::FAN_MAX :
                     psuhk_pkg::FAN_THERMAL;
  always_comb begin
    if (!main_rails_en && !sleeping) begin
      fan_a_level = psuhk_pkg::FAN_OFF;
      fan_b_level = psuhk_pkg::FAN_OFF;
    end else if (!main_rails_en) begin
      fan_a_level = fan_sel_b ? psuhk_pkg::FAN_OFF : psuhk_pkg::FAN_MIN;
      fan_b_level = fan_sel_b ? psuhk_pkg::FAN_MIN : psuhk_pkg::FAN_OFF;
      if (!fanmax_n_s) begin
        fan_a_level = fan_sel_b ? psuhk_pkg::FAN_OFF : psuhk_pkg::FAN_MAX;
        fan_b_level = fan_sel_b ? psuhk_pkg::FAN_MAX : psuhk_pkg::FAN_OFF;
      end
    end else begin
      fan_a_level = run_lvl;
      fan_b_level = run_lvl;
    end
  end
  assign fan_a_drive_on = fan_a_level != psuhk_pkg::FAN_OFF;
  assign fan_b_drive_on = fan_b_level != psuhk_pkg::FAN_OFF;

endmodule // psuhk_seq

// ===== psuhk_seq_sva.sv
// Concurrent checks on the ports of the housekeeping sequencer.
`timescale 1ns/1ps
module psuhk_seq_sva #(
  parameter int unsigned GOOD_DLY_CYC = 200,
  parameter int unsigned WARN_CYC     = 40,
  parameter int unsigned DEBOUNCE_CYC = 8
) (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Board pins
  input wire logic       remote_on_request_n,
  input wire logic       sleep_request_n,
  input wire logic       fan_max_speed_request_n,
  input wire logic       power_good_out,
  input wire logic       fan_tach_out,
  // Monitors and enables
  input wire logic       ac_ok,
  input wire logic       energy_ok,
  input wire logic       main_rails_ok,
  input wire logic       output_fault,
  input wire logic       main_rails_en,
  input wire logic       standby_5v_rail_en,
  input wire logic [1:0] fan_a_level
);
  logic [15:0] ok_cnt_r;
  logic [15:0] low_cnt_r;
  logic [15:0] warn_cnt_r;

  // Run lengths; they wrap after 65535 cycles, so keep runs shorter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ok_cnt_r   <= 16'h0;
      low_cnt_r  <= 16'h0;
      warn_cnt_r <= 16'h0;
    end else begin
      ok_cnt_r   <= main_rails_ok ? ok_cnt_r + 16'h1 : 16'h0;
      low_cnt_r  <= remote_on_request_n ? 16'h0 : low_cnt_r + 16'h1;
      warn_cnt_r <= power_good_out ? 16'h0 : warn_cnt_r + 16'h1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_GOOD_RAILS: assert property (
    power_good_out |-> main_rails_ok && energy_ok && main_rails_en)
    else $error("power good without rails or energy");
  AST_GOOD_DROP: assert property (
    $fell(main_rails_ok) || $fell(energy_ok) |-> (!power_good_out)[*2])
    else $error("power good kept after loss");
  AST_GOOD_DELAY: assert property (
    $rose(power_good_out) |-> ok_cnt_r >= GOOD_DLY_CYC / 2
      && ok_cnt_r < GOOD_DLY_CYC * 5 / 2)
    else $error("power good delay out of range");
  AST_WARN_LEAD: assert property (
    $fell(main_rails_en) && !$past(output_fault)
      |-> warn_cnt_r >= WARN_CYC / 2)
    else $error("rails dropped without warning time");
  AST_SLEEP_MAIN: assert property (
    (!sleep_request_n)[*4] |-> !main_rails_en)
    else $error("main rails on in sleep");
  AST_REMOTE_OFF: assert property (
    $rose(remote_on_request_n) |-> ##[1:80] !main_rails_en)
    else $error("main rails stay on after off request");
  AST_STANDBY_AC: assert property (
    ac_ok[*2] |-> standby_5v_rail_en)
    else $error("standby rail off with ac present");
  AST_DEBOUNCE: assert property (
    $rose(main_rails_en) |-> low_cnt_r >= DEBOUNCE_CYC)
    else $error("rails on before request settled");
  AST_FAN_MAX: assert property (
    (!fan_max_speed_request_n && main_rails_en)[*4]
      |-> fan_a_level == psuhk_pkg::FAN_MAX)
    else $error("fan override ignored");
  AST_TACH_OC: assert property (
    fan_tach_out == 1'b0)
    else $error("tach output drives high");
  AST_INVALID: assert property (
    (remote_on_request_n && !sleep_request_n)[*8]
      |-> !power_good_out && !main_rails_en)
    else $error("invalid pair not kept safe");
endmodule // psuhk_seq_sva

bind psuhk_seq psuhk_seq_sva #(
  .GOOD_DLY_CYC(GOOD_DLY_CYC),
  .WARN_CYC(WARN_CYC),
  .DEBOUNCE_CYC(DEBOUNCE_CYC)
) chk_u (
  .pclk, .presetn, .remote_on_request_n, .sleep_request_n,
  .fan_max_speed_request_n, .power_good_out, .fan_tach_out, .ac_ok,
  .energy_ok, .main_rails_ok, .output_fault, .main_rails_en,
  .standby_5v_rail_en, .fan_a_level
);

// ===== psuhk_board.sv
// Board side model: request pins and the pulled-up tachometer line.
`timescale 1ns/1ps
module psuhk_board (
  // Clock
  input wire logic pclk,
  // Wishes of the test
  input wire logic want_on,
  input wire logic want_sleep,
  input wire logic want_fanmax,
  input wire logic allow_bad,
  // Request pins
  output logic     remote_on_request_n,
  output logic     sleep_request_n,
  output logic     fan_max_speed_request_n,
  // Tachometer line
  input wire logic fan_tach_out,
  input wire logic fan_tach_oe,
  output logic     tach_pin,
  output int       tach_edges
);
  logic tach_d_r;

  // The board pull-up holds the line high whenever the supply lets go.
  assign tach_pin = fan_tach_oe ? fan_tach_out : 1'b1;

  initial begin
    {remote_on_request_n, sleep_request_n} = 2'h3;
    {fan_max_speed_request_n, tach_d_r} = 2'h3;
    tach_edges = 0;
  end

  always @(posedge pclk) begin
    remote_on_request_n     <= !want_on;
    // Sleep with the supply off is only sent when a test asks for it.
    sleep_request_n         <= !(want_sleep && (want_on || allow_bad));
    fan_max_speed_request_n <= !want_fanmax;
    tach_d_r                <= tach_pin;
    if (tach_pin != tach_d_r) tach_edges <= tach_edges + 1;
  end
endmodule // psuhk_board

// ===== psuhk_seq_tb.sv
// Self-checking bench of the housekeeping sequencer.
`timescale 1ns/1ps
module psuhk_seq_tb;
  localparam int GD = 200;
  localparam int RS = 500;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        remote_on_request_n, sleep_request_n, power_good_out;
  logic        fan_max_speed_request_n, fan_tach_out, fan_tach_oe;
  logic        ac_ok, energy_ok, main_rails_ok, standby_rails_ok;
  logic        output_fault, fan_a_tach, fan_b_tach, tach_pin;
  logic        main_rails_en, digital_12v_rail_en, standby_5v_rail_en;
  logic        fan_a_drive_on, fan_b_drive_on;
  logic [1:0]  fan_a_level, fan_b_level, mon;
  logic        want_on, want_sleep, want_fanmax, allow_bad;
  logic        ac_w, energy_w, fault_w, spin_a, spin_b;
  logic [2:0]  tk;
  int          tach_edges, n_errors, comparisons, c, e0;

  psuhk_seq #(.GOOD_DLY_CYC(GD), .WARN_CYC(40), .ON_TMO_CYC(1000),
    .SB_TMO_CYC(1000), .RESTART_CYC(RS), .DEBOUNCE_CYC(8),
    .TACH_TMO_CYC(100)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .remote_on_request_n, .sleep_request_n, .fan_max_speed_request_n,
    .power_good_out, .fan_tach_out, .fan_tach_oe, .ac_ok, .energy_ok,
    .main_rails_ok, .standby_rails_ok, .output_fault, .fan_a_tach,
    .fan_b_tach, .main_rails_en, .digital_12v_rail_en,
    .standby_5v_rail_en, .fan_a_drive_on, .fan_a_level,
    .fan_b_drive_on, .fan_b_level);

  psuhk_board board_u (.pclk, .want_on, .want_sleep, .want_fanmax,
    .allow_bad, .remote_on_request_n, .sleep_request_n,
    .fan_max_speed_request_n, .fan_tach_out, .fan_tach_oe, .tach_pin,
    .tach_edges);

  assign mon = {power_good_out, main_rails_en};

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Rails report good one cycle after their enable, like a fast supply.
  always @(posedge pclk) begin
    ac_ok            <= ac_w;
    energy_ok        <= energy_w;
    output_fault     <= fault_w;
    main_rails_ok    <= main_rails_en;
    standby_rails_ok <= standby_5v_rail_en;
    tk               <= tk + 3'h1;
    if (tk == 3'h0 && spin_a) fan_a_tach <= ~fan_a_tach;
    if (tk == 3'h0 && spin_b) fan_b_tach <= ~fan_b_tach;
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_for(input int k, input logic v, input int n,
                          output int cnt);
    cnt = 0;
    while (mon[k] !== v && cnt < n) begin
      @(negedge pclk);
      cnt++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic wrap_up;
    $display("%0d mismatches in %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, presetn, allow_bad} = 5'h0;
    {want_on, want_sleep, want_fanmax, fault_w, output_fault} = 5'h0;
    {main_rails_ok, standby_rails_ok, fan_a_tach, fan_b_tach} = 4'h0;
    {ac_w, energy_w, spin_a, spin_b, ac_ok, energy_ok} = 6'h3F;
    {paddr, pwdata, tk} = 47'h0;
    {n_errors, comparisons} = 64'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    chk(main_rails_en, 1'b0, "rails on after reset");
    chk(standby_5v_rail_en, 1'b1, "standby off with ac");
    apb(1'b0, psuhk_pkg::ADDR_CTRL, 32'h0, rd, er);
    chk(rd, 32'h0, "control reset value");
    apb(1'b1, psuhk_pkg::ADDR_CTRL, 32'h1, rd, er);
    apb(1'b0, psuhk_pkg::ADDR_CTRL, 32'h0, rd, er);
    chk(rd[0], 1'b1, "fan select lost");
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    chk(er, 1'b1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    want_on = 1'b1;
    wait_for(0, 1'b1, 100, c);
    chk(c < 100, 1'b1, "rails never enabled");
    chk(c >= 8, 1'b1, "request not filtered");
    chk(digital_12v_rail_en, 1'b1, "digital rail off");
    wait_for(1, 1'b1, 600, c);
    chk(c >= GD / 2 && c < GD * 5 / 2, 1'b1, "good delay");
    apb(1'b0, psuhk_pkg::ADDR_STATUS, 32'h0, rd, er);
    chk(rd[1:0], 2'h3, "status rails and good");
    chk(fan_a_level, psuhk_pkg::FAN_THERMAL, "fan not thermal");
    want_fanmax = 1'b1;
    cyc(8);
    chk({fan_a_level, fan_b_level}, 4'hF, "override ignored");
    want_fanmax = 1'b0;
    e0 = tach_edges;
    cyc(80);
    chk((tach_edges - e0) inside {[9:11]}, 1'b1, "tach count");
    spin_b = 1'b0;
    cyc(130);
    e0 = tach_edges;
    cyc(60);
    chk(tach_edges == e0, 1'b1, "tach runs with lock");
    spin_b = 1'b1;
    energy_w = 1'b0;
    cyc(3);
    chk(mon, 2'h1, "good on energy loss");
    energy_w = 1'b1;
    want_on = 1'b0;
    wait_for(0, 1'b0, 200, c);
    chk(c < 200, 1'b1, "rails on after off request");
    {want_on, want_sleep} = 2'h3;
    cyc(40);
    chk({main_rails_en, digital_12v_rail_en}, 2'h1, "sleep rails");
    chk({fan_a_drive_on, fan_b_drive_on, fan_b_level},
        {2'h1, psuhk_pkg::FAN_MIN}, "sleep fans");
    want_sleep = 1'b0;
    wait_for(0, 1'b1, 100, c);
    chk(c < 100, 1'b1, "no wake from sleep");
    want_on = 1'b0;
    cyc(100);
    chk({main_rails_en, digital_12v_rail_en}, 2'h0, "off rails");
    chk({fan_a_drive_on, fan_b_drive_on}, 2'h0, "fans when off");
    {allow_bad, want_sleep} = 2'h3;
    cyc(40);
    chk({mon, digital_12v_rail_en}, 3'h0, "invalid pair");
    {allow_bad, want_sleep, ac_w} = 3'h0;
    cyc(4);
    chk(standby_5v_rail_en, 1'b0, "standby without ac");
    ac_w = 1'b1;
    cyc(4);
    chk(standby_5v_rail_en, 1'b1, "standby after ac");
    want_on = 1'b1;
    wait_for(0, 1'b1, 100, c);
    fault_w = 1'b1;
    cyc(4);
    chk(main_rails_en, 1'b0, "fault ignored");
    fault_w = 1'b0;
    cyc(RS / 2);
    chk(main_rails_en, 1'b0, "fault not latched");
    want_on = 1'b0;
    cyc(RS / 2);
    want_on = 1'b1;
    cyc(60);
    chk(main_rails_en, 1'b0, "short off cycle restarts");
    want_on = 1'b0;
    cyc(RS + 60);
    want_on = 1'b1;
    wait_for(0, 1'b1, 100, c);
    chk(main_rails_en, 1'b1, "no restart after off");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // psuhk_seq_tb
